// ---- exsk_map.svh ----
`ifndef EXSK_MAP_SVH
`define EXSK_MAP_SVH
// ************************************************************
// Field widths and reset values
// ************************************************************
`define EXSK_DW 8
`define EXSK_PW 16
`define EXSK_PAW 12
`define EXSK_MAW 9
`define EXSK_BITW 3
// Last program memory page number (upper four address bits of last page)
`define EXSK_LAST_PAGE 4'hF
`define EXSK_WORK_RST 8'h00
`define EXSK_TBL_RST 8'h00
`define EXSK_ZERO_BYTE 8'h00
`endif

// ---- exsk_pkg.sv ----
`default_nettype none
`include "exsk_map.svh"
package exsk_pkg;
	// Extended instruction group
	typedef enum logic [3:0] {
		EXSK_NOP, EXSK_SZA, EXSK_SZB, EXSK_TRD, EXSK_TRDL,
		EXSK_ITRD, EXSK_ITRDL, EXSK_XORA, EXSK_XORM
	} exsk_op_t;
	// Decoded instruction from the fetch pipeline
	typedef struct packed {
		exsk_op_t op;
		logic [`EXSK_MAW-1:0] addr;
		logic [`EXSK_BITW-1:0] bit_sel;
	} exsk_instr_t;
	// Execution state
	typedef enum logic [1:0] {EXSK_IDLE, EXSK_RD, EXSK_TBL, EXSK_DUMMY}
		exsk_state_t;
endpackage
`default_nettype wire

// ---- exsk_prog_rom.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "exsk_map.svh"
// ************************************************************
// Program memory with registered read data
// ************************************************************
module exsk_prog_rom (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [`EXSK_PAW-1:0] wr_addr,
	input wire logic [`EXSK_PW-1:0] wr_data,
	input wire logic [`EXSK_PAW-1:0] rd_addr,
	output logic [`EXSK_PW-1:0] rd_data
);
	logic [`EXSK_PW-1:0] mem [0:(1<<`EXSK_PAW)-1]; // Storage array
	// Load port and registered read
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ---- exsk_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "exsk_map.svh"
// Operation
// - Copy byte to working; skip if zero
// - Skip with one dummy cycle when selected bit clear
// - Current-page table read to memory, latch
// - Last-page table read to memory, latch
// - Increment pointer low, read combined pointer
// - Increment pointer low, read last page
// - Working XOR byte into working, zero flag
// - Byte XOR working into memory, zero flag
module exsk_exec import exsk_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire exsk_instr_t instr,
	input wire logic [`EXSK_PAW-1:0] pc_cur,
	input wire logic [`EXSK_DW-1:0] tbl_high_ptr,
	input wire logic prog_wr_en,
	input wire logic [`EXSK_PAW-1:0] prog_wr_addr,
	input wire logic [`EXSK_PW-1:0] prog_wr_data,
	input wire logic [`EXSK_DW-1:0] mem_rdata,
	input wire logic tbl_low_load,
	input wire logic [`EXSK_DW-1:0] tbl_low_wdata,
	output logic mem_re_q,
	output logic [`EXSK_MAW-1:0] mem_addr_q,
	output logic mem_we_q,
	output logic [`EXSK_DW-1:0] mem_wdata_q,
	output logic [`EXSK_DW-1:0] working_q,
	output logic zero_flag_q,
	output logic [`EXSK_DW-1:0] table_high_latch_q,
	output logic [`EXSK_DW-1:0] table_pointer_low_q,
	output logic busy_q,
	output logic skip_q,
	output logic done_q
);
	// ************************************************************
	// State
	// ************************************************************
	exsk_state_t state_q; // Sequencer state
	exsk_instr_t cur_q; // Instruction in flight
	logic [`EXSK_PAW-1:0] rom_addr_q; // Table fetch address, kept for checks
	logic [`EXSK_PW-1:0] rom_data; // Fetched program word
	logic [`EXSK_DW-1:0] xor_val; // XOR result
	logic bit_clear; // Selected bit is zero
	logic byte_zero; // Whole byte is zero
	logic [`EXSK_DW-1:0] ptr_inc; // Incremented pointer low
	logic accept; // New instruction taken
	logic is_table; // Table group
	logic is_preinc; // Pre-increment variants
	logic is_last; // Last-page variants

	// ************************************************************
	// Decoding
	// ************************************************************
	function automatic logic op_table(input exsk_op_t op);
		op_table = (op == EXSK_TRD) || (op == EXSK_TRDL) ||
			(op == EXSK_ITRD) || (op == EXSK_ITRDL);
	endfunction
	assign accept = instr_valid && !busy_q && (instr.op != EXSK_NOP);
	assign is_table = op_table(instr.op);
	assign is_preinc = (instr.op == EXSK_ITRD) || (instr.op == EXSK_ITRDL);
	assign is_last = (instr.op == EXSK_TRDL) || (instr.op == EXSK_ITRDL);
	// Pre-increment wraps within the low pointer byte
	assign ptr_inc = 8'(table_pointer_low_q + 8'h01);
	assign xor_val = working_q ^ mem_rdata;
	assign byte_zero = (mem_rdata == `EXSK_ZERO_BYTE);
	assign bit_clear = !mem_rdata[cur_q.bit_sel];

	// Table fetch address per variant
	logic [`EXSK_DW-1:0] ptr_use; // Pointer low after optional increment
	logic [`EXSK_PAW-1:0] tbl_addr; // Selected program address
	assign ptr_use = is_preinc ? ptr_inc : table_pointer_low_q;
	assign tbl_addr = is_last ? {`EXSK_LAST_PAGE, ptr_use} :
		(instr.op == EXSK_ITRD) ?
		{tbl_high_ptr[`EXSK_PAW-`EXSK_DW-1:0], ptr_use} :
		{pc_cur[`EXSK_PAW-1:`EXSK_DW], ptr_use};

	// Word is read at the accept edge so it stands in the table state;
	// a registered address here would hand over the previous word
	exsk_prog_rom u_rom (
		.clk(clk),
		.wr_en(prog_wr_en),
		.wr_addr(prog_wr_addr),
		.wr_data(prog_wr_data),
		.rd_addr(tbl_addr),
		.rd_data(rom_data)
	);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= EXSK_IDLE;
			cur_q <= '0;
			rom_addr_q <= '0;
			mem_re_q <= 1'b0;
			mem_addr_q <= '0;
			mem_we_q <= 1'b0;
			mem_wdata_q <= `EXSK_ZERO_BYTE;
			working_q <= `EXSK_WORK_RST;
			zero_flag_q <= 1'b0;
			table_high_latch_q <= `EXSK_TBL_RST;
			table_pointer_low_q <= `EXSK_TBL_RST;
			busy_q <= 1'b0;
			skip_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			mem_we_q <= 1'b0;
			mem_re_q <= 1'b0;
			skip_q <= 1'b0;
			done_q <= 1'b0;
			case (state_q)
				EXSK_IDLE: begin
					if (tbl_low_load) begin
						table_pointer_low_q <= tbl_low_wdata;
					end
					if (accept) begin
						cur_q <= instr;
						mem_addr_q <= instr.addr;
						busy_q <= 1'b1;
						if (is_table) begin
							rom_addr_q <= tbl_addr;
							if (is_preinc) begin
								// Pointer bumps before fetch
								table_pointer_low_q <= ptr_inc;
							end
							state_q <= EXSK_TBL;
						end else begin
							mem_re_q <= 1'b1;
							state_q <= EXSK_RD;
						end
					end
				end
				EXSK_RD: begin
					// Operand byte now on mem_rdata
					case (cur_q.op)
						EXSK_SZA: begin
							working_q <= mem_rdata;
							skip_q <= byte_zero;
						end
						EXSK_SZB: begin
							skip_q <= bit_clear;
						end
						EXSK_XORA: begin
							working_q <= xor_val;
							zero_flag_q <= (xor_val == `EXSK_ZERO_BYTE);
						end
						EXSK_XORM: begin
							mem_we_q <= 1'b1;
							mem_wdata_q <= xor_val;
							zero_flag_q <= (xor_val == `EXSK_ZERO_BYTE);
						end
						default: begin
						end
					endcase
					if ((cur_q.op == EXSK_SZA && byte_zero) ||
						(cur_q.op == EXSK_SZB && bit_clear)) begin
						state_q <= EXSK_DUMMY; // Dummy cycle
					end else begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						state_q <= EXSK_IDLE;
					end
				end
				EXSK_TBL: begin
					// Word ready: low to memory, high to latch
					mem_we_q <= 1'b1;
					mem_wdata_q <= rom_data[`EXSK_DW-1:0];
					table_high_latch_q <= rom_data[`EXSK_PW-1:`EXSK_DW];
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= EXSK_IDLE;
				end
				EXSK_DUMMY: begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
					state_q <= EXSK_IDLE;
				end
				default: begin
					state_q <= EXSK_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	skip_copy_a: assert property (@(posedge clk) disable iff (rst)
		state_q == EXSK_RD && cur_q.op == EXSK_SZA |=>
		working_q == $past(mem_rdata) && $stable(zero_flag_q) &&
		skip_q == ($past(mem_rdata) == 8'h00))
		else $error("skip copy wrong");
	skip_bit_a: assert property (@(posedge clk) disable iff (rst)
		state_q == EXSK_RD && cur_q.op == EXSK_SZB && bit_clear
		|=> skip_q ##1 done_q)
		else $error("bit skip wrong");
	table_cur_a: assert property (@(posedge clk) disable iff (rst)
		accept && instr.op == EXSK_TRD |=>
		rom_addr_q == {$past(pc_cur[11:8]), $past(table_pointer_low_q)})
		else $error("current page address wrong");
	table_last_a: assert property (@(posedge clk) disable iff (rst)
		accept && instr.op == EXSK_TRDL |=> rom_addr_q[11:8] == 4'hF
		##1 mem_we_q && table_high_latch_q == $past(rom_data[15:8]))
		else $error("last page read wrong");
	preinc_ptr_a: assert property (@(posedge clk) disable iff (rst)
		accept && instr.op == EXSK_ITRD |=>
		table_pointer_low_q == $past(table_pointer_low_q) + 8'h01 &&
		rom_addr_q[7:0] == table_pointer_low_q)
		else $error("preincrement wrong");
	preinc_last_a: assert property (@(posedge clk) disable iff (rst)
		accept && instr.op == EXSK_ITRDL |=>
		rom_addr_q == {4'hF, table_pointer_low_q})
		else $error("preincrement last wrong");
	xor_work_a: assert property (@(posedge clk) disable iff (rst)
		state_q == EXSK_RD && cur_q.op == EXSK_XORA |=>
		working_q == ($past(working_q) ^ $past(mem_rdata)) && !mem_we_q &&
		zero_flag_q == (working_q == `EXSK_ZERO_BYTE))
		else $error("xor to working wrong");
	xor_mem_a: assert property (@(posedge clk) disable iff (rst)
		state_q == EXSK_RD && cur_q.op == EXSK_XORM |=> mem_we_q &&
		mem_wdata_q == ($past(working_q) ^ $past(mem_rdata)) &&
		zero_flag_q == (mem_wdata_q == 8'h00) && $stable(working_q))
		else $error("xor to memory wrong");
	noskip_single_a: assert property (@(posedge clk) disable iff (rst)
		state_q == EXSK_RD && cur_q.op == EXSK_SZB && !bit_clear
		|=> done_q && !skip_q && !busy_q)
		else $error("unmet skip not single cycle");
endmodule
`default_nettype wire

// ---- exsk_dmem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "exsk_map.svh"
// ****
// Data memory beside the core
// ****
module exsk_dmem_model (
	input wire logic clk,
	input wire logic re,
	input wire logic we,
	input wire logic [`EXSK_MAW-1:0] addr,
	input wire logic [`EXSK_DW-1:0] wdata,
	output logic [`EXSK_DW-1:0] rdata
);
	// Byte store, preloaded by the bench
	logic [`EXSK_DW-1:0] mem [0:511];
	logic [`EXSK_DW-1:0] idle_q = 8'hA5; // Shown while no read stands
	// Read answers in the cycle of the request; idle bus toggles
	assign rdata = re ? mem[addr] : idle_q;
	always @(posedge clk) begin
		idle_q <= ~idle_q;
		// Write-back from table reads and XOR to memory
		if (we) mem[addr] <= wdata;
	end
endmodule
`default_nettype wire

// ---- ext_skip_table_xor_exec_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "exsk_map.svh"
// ****
// Bench for the extended skip, table and XOR group
// ****
module ext_skip_table_xor_exec_tb_top import exsk_pkg::*;;
	logic clk, rst, iv, pwe, tll, re, we, zf, busy, skip, done;
	exsk_instr_t ins;
	logic [11:0] pc, pwa;
	logic [15:0] pwd;
	logic [7:0] thp, tlw, rd, wd, wrk, tbh, tpl, ewrk, etbh, etpl;
	logic [8:0] ma;
	logic ezf;
	logic [7:0] sh [0:511]; // Expected memory image
	logic [31:0] seed, r1, r2;
	int error_cnt, n_tests, cyc;
	exsk_exec u_exsk_exec (.clk(clk), .rst(rst), .instr_valid(iv),
		.instr(ins), .pc_cur(pc), .tbl_high_ptr(thp), .prog_wr_en(pwe),
		.prog_wr_addr(pwa), .prog_wr_data(pwd), .mem_rdata(rd),
		.tbl_low_load(tll), .tbl_low_wdata(tlw), .mem_re_q(re),
		.mem_addr_q(ma), .mem_we_q(we), .mem_wdata_q(wd),
		.working_q(wrk), .zero_flag_q(zf), .table_high_latch_q(tbh),
		.table_pointer_low_q(tpl), .busy_q(busy), .skip_q(skip),
		.done_q(done));
	exsk_dmem_model u_exsk_dmem_model (.clk(clk), .re(re), .we(we),
		.addr(ma), .wdata(wd), .rdata(rd));
	// ****
	// Helpers
	// ****
	task nxt(output logic [31:0] r);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		r = seed;
	endtask
	// Program address a table read should fetch
	function automatic logic [11:0] taddr(exsk_op_t o, logic [3:0] pg,
		logic [7:0] p);
		if (o == EXSK_TRD) return {pg, p};
		if (o == EXSK_ITRD) return {~pg, p};
		return {`EXSK_LAST_PAGE, p};
	endfunction
	task chk(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		$display("Checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// One instruction: prepare memory and tables, issue, then compare
	task do_op(input exsk_op_t o, input logic [8:0] a, input logic [2:0] b,
		input logic [7:0] v, input logic [15:0] w, input logic [3:0] pg);
		logic tb, esk, sk;
		logic [7:0] p;
		int n;
		tb = o inside {EXSK_TRD, EXSK_TRDL, EXSK_ITRD, EXSK_ITRDL};
		p = v + {7'h00, o inside {EXSK_ITRD, EXSK_ITRDL}};
		sh[a] = v;
		u_exsk_dmem_model.mem[a] = v;
		@(posedge clk);
		pc <= {pg, w[7:0]};
		thp <= {w[15:12], ~pg};
		tll <= tb;
		tlw <= v;
		pwe <= tb;
		pwa <= taddr(o, pg, p);
		pwd <= w;
		@(posedge clk);
		tll <= 1'b0;
		pwe <= 1'b0;
		iv <= 1'b1;
		ins <= '{op: o, addr: a, bit_sel: b};
		@(posedge clk);
		iv <= 1'b0;
		sk = 1'b0;
		for (n = 1; n < 10; n++) begin
			#1;
			if (skip === 1'b1) sk = 1'b1;
			if (done === 1'b1) break;
			@(posedge clk);
		end
		esk = (o == EXSK_SZA && v == 8'h00) || (o == EXSK_SZB && !v[b]);
		// Zero flag from the old working value, before it is replaced
		if (o == EXSK_XORA || o == EXSK_XORM) ezf = (ewrk ^ v) == 8'h00;
		if (o == EXSK_SZA) ewrk = v;
		if (o == EXSK_XORM) sh[a] = ewrk ^ v;
		if (o == EXSK_XORA) ewrk ^= v;
		if (tb) {etbh, sh[a], etpl} = {w, p};
		@(posedge clk);
		#1;
		chk("skip", {15'h0000, sk}, {15'h0000, esk});
		chk("cycles", n[15:0], esk ? 16'h0003 : 16'h0002);
		chk("working", {8'h00, wrk}, {8'h00, ewrk});
		chk("zero", {15'h0000, zf}, {15'h0000, ezf});
		chk("memory", {8'h00, u_exsk_dmem_model.mem[a]}, {8'h00, sh[a]});
		chk("latch", {8'h00, tbh}, {8'h00, etbh});
		chk("pointer", {8'h00, tpl}, {8'h00, etpl});
		chk("busy", {15'h0000, busy}, 16'h0000);
		chk("address", {7'h00, ma}, {7'h00, a});
	endtask
	// ****
	// Clock, timeout, sequence
	// ****
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		{rst, iv, pwe, tll, ins, pc, thp, tlw, pwa, pwd} = '0;
		rst = 1'b1;
		{error_cnt, n_tests, cyc} = '0;
		{ewrk, ezf, etbh, etpl} = '0;
		seed = 32'hED7445EB;
		for (int i = 0; i < 512; i++) begin
			nxt(r1);
			sh[i] = r1[7:0];
			u_exsk_dmem_model.mem[i] = r1[7:0];
		end
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Corner cases: zero byte, top bit clear, pointer wrap, zero result
		do_op(EXSK_SZA, 9'h1FF, 3'h0, 8'h00, 16'h0000, 4'h0);
		do_op(EXSK_SZB, 9'h000, 3'h7, 8'h7F, 16'h0000, 4'h0);
		do_op(EXSK_ITRD, 9'h010, 3'h0, 8'hFF, 16'hA55A, 4'h3);
		do_op(EXSK_ITRDL, 9'h011, 3'h0, 8'hFF, 16'h3CC3, 4'h3);
		do_op(EXSK_XORA, 9'h012, 3'h0, ewrk, 16'h0000, 4'h0);
		for (int i = 0; i < 200; i++) begin
			nxt(r1);
			nxt(r2);
			do_op(exsk_op_t'({1'b0, r1[2:0]} + 4'h1), r1[11:3], r1[14:12],
				r1[15] ? r1[23:16] : 8'h00, r2[15:0], r2[19:16]);
		end
		complete_run;
	end
endmodule
`default_nettype wire
